// File: sbch_regs.vh
`ifndef SBCH_REGS_VH
`define SBCH_REGS_VH

// Session opener and operation command codes
`define SBCH_BAUD_CODE      8'h86
`define SBCH_CMD_RAM        8'h10
`define SBCH_CMD_SUM        8'h20
`define SBCH_CMD_INFO       8'h30
`define SBCH_CMD_ERASE      8'h40
`define SBCH_CMD_PROG       8'h50
`define SBCH_CMD_PROT       8'h60

// Error acknowledge low nibbles; high nibble is the preceding command's for a rejected command byte, the current command's for a later checksum error
`define SBCH_ERR_CMD        4'h1
`define SBCH_ERR_NOERASE    4'h4
`define SBCH_ERR_PROT       4'h6
`define SBCH_ERR_RX         4'h8

// Status acknowledge bytes
`define SBCH_ERASE_OK       8'h4f
`define SBCH_ERASE_FAIL     8'h4c
`define SBCH_PROT_OK        8'h6f
`define SBCH_PROT_FAIL      8'h6c
`define SBCH_PROT_FIN_OK    8'h31
`define SBCH_PROT_FIN_FAIL  8'h34

// Flash and RAM address map
`define SBCH_PW_BASE        24'h04fef4
`define SBCH_PW_LAST        5'h0b
`define SBCH_INFO_BASE      24'h04fef0
`define SBCH_INFO_LAST      5'h03
`define SBCH_FLASH_BASE     24'h010000
`define SBCH_FLASH_BYTES    262144
`define SBCH_RAM_LO         33'h000001000
`define SBCH_RAM_HI         33'h000004dff
`define SBCH_HDR_LAST       5'h05

`endif

// File: sbch_boot_handler.v
`timescale 1ns/1ps
`default_nettype none
`include "sbch_regs.vh"

module sbch_boot_handler #(
    parameter FLASH_BYTES = `SBCH_FLASH_BYTES,
    parameter TX_WIDTH    = 8
) (
    // Clock and reset
    input  wire                core_clk,
    input  wire                rst_n,
    // Boot strap pin and baud detector
    input  wire                bootModePin,
    input  wire                baudOk,
    // Received characters
    input  wire                rxValid,
    input  wire [7:0]          rxData,
    input  wire                rxError,
    output wire                rxReady,
    // Transmitted characters
    output wire                txValid,
    output wire [TX_WIDTH-1:0] txData,
    input  wire                txReady,
    // Flash read port
    output reg                 flashRdReq_reg,
    output reg  [23:0]         flashRdAddr_reg,
    input  wire                flashRdAck,
    input  wire [7:0]          flashRdData,
    // Byte write port, flash or RAM
    output reg                 wrReq_reg,
    output reg                 wrToFlash_reg,
    output reg  [31:0]         wrAddr_reg,
    output reg  [7:0]          wrData_reg,
    input  wire                wrDone,
    // Flash erase and protection
    input  wire                protActive,
    output reg                 eraseReq_reg,
    input  wire                eraseDone,
    input  wire                eraseOk,
    output reg                 protReq_reg,
    input  wire                protDone,
    input  wire                protOk,
    // Hand-off to the loaded program
    output reg                 runReq_reg,
    output reg  [31:0]         runAddr_reg
);

    localparam S_IDLE  = 5'd0;
    localparam S_BAUD  = 5'd1;
    localparam S_DEAD  = 5'd2;
    localparam S_CMD   = 5'd3;
    localparam S_PW    = 5'd4;
    localparam S_PWRD  = 5'd5;
    localparam S_PWCK  = 5'd6;
    localparam S_HDR   = 5'd7;
    localparam S_HDRCK = 5'd8;
    localparam S_DATA  = 5'd9;
    localparam S_WR    = 5'd10;
    localparam S_DCK   = 5'd11;
    localparam S_ERASE = 5'd12;
    localparam S_PROT  = 5'd13;
    localparam S_SUM   = 5'd14;
    localparam S_INFO  = 5'd15;
    localparam S_RUN   = 5'd16;
    localparam S_TAIL  = 5'd17;

    localparam [31:0] SUM_LAST_W = FLASH_BYTES - 1;
    localparam [18:0] SUM_LAST   = SUM_LAST_W[18:0];

    function [7:0] errAck;
        input [3:0] hi;
        input [3:0] lo;
        begin
            errAck = {hi, lo};
        end
    endfunction

    reg        bootMeta_reg;
    reg        bootSync_reg;
    reg [4:0]  state_reg;
    reg        sendPend_reg;
    reg [7:0]  sendByte_reg;
    reg [7:0]  cmd_reg;
    reg [3:0]  lastHi_reg;
    reg        erased_reg;
    reg [18:0] cnt_reg;
    reg [15:0] sum_reg;
    reg        rxErr_reg;
    reg        pwBad_reg;
    reg [31:0] addr_reg;
    reg [15:0] len_reg;
    reg [7:0]  byte_reg;

    // Two-entry transmit buffer
    reg [TX_WIDTH-1:0] txMem [0:1];
    reg                txWp_reg;
    reg                txRp_reg;
    reg [1:0]          txCnt_reg;

    wire       rxWant  = (state_reg == S_BAUD) || (state_reg == S_CMD) ||
                         (state_reg == S_PW) || (state_reg == S_PWCK) ||
                         (state_reg == S_HDR) || (state_reg == S_HDRCK) ||
                         (state_reg == S_DATA) || (state_reg == S_DCK);
    wire       busy    = sendPend_reg;
    wire       take    = rxValid && rxReady;
    wire       push    = sendPend_reg && (txCnt_reg != 2'd2);
    wire       pop     = txValid && txReady;
    wire [7:0] ckSum   = sum_reg[7:0] + rxData;
    wire       ckErr   = rxErr_reg || rxError;
    wire [32:0] ramEnd = {1'b0, addr_reg} + {17'h00000, len_reg} - 33'h000000001;
    wire       ramFits = (len_reg != 16'h0000) && ({1'b0, addr_reg} >= `SBCH_RAM_LO) &&
                         (ramEnd <= `SBCH_RAM_HI);

    // Byte-wide receive; the FSM stalls input while an answer is pending
    assign rxReady = rxWant && !busy;
    assign txValid = (txCnt_reg != 2'd0);
    assign txData  = txMem[txRp_reg];

    always @(posedge core_clk) begin
        if (!rst_n) begin
            txWp_reg  <= 1'b0;
            txRp_reg  <= 1'b0;
            txCnt_reg <= 2'd0;
        end else begin
            if (push) begin
                txMem[txWp_reg] <= sendByte_reg[TX_WIDTH-1:0];
                txWp_reg        <= ~txWp_reg;
            end
            if (pop)
                txRp_reg <= ~txRp_reg;
            if (push && !pop)
                txCnt_reg <= txCnt_reg + 2'd1;
            else if (pop && !push)
                txCnt_reg <= txCnt_reg - 2'd1;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            bootMeta_reg    <= 1'b0;
            bootSync_reg    <= 1'b0;
            state_reg       <= S_IDLE;
            sendPend_reg    <= 1'b0;
            sendByte_reg    <= 8'h00;
            cmd_reg         <= 8'h00;
            lastHi_reg      <= 4'h0;
            erased_reg      <= 1'b0;
            cnt_reg         <= 19'h00000;
            sum_reg         <= 16'h0000;
            rxErr_reg       <= 1'b0;
            pwBad_reg       <= 1'b0;
            addr_reg        <= 32'h00000000;
            len_reg         <= 16'h0000;
            byte_reg        <= 8'h00;
            flashRdReq_reg  <= 1'b0;
            flashRdAddr_reg <= 24'h000000;
            wrReq_reg       <= 1'b0;
            wrToFlash_reg   <= 1'b0;
            wrAddr_reg      <= 32'h00000000;
            wrData_reg      <= 8'h00;
            eraseReq_reg    <= 1'b0;
            protReq_reg     <= 1'b0;
            runReq_reg      <= 1'b0;
            runAddr_reg     <= 32'h00000000;
        end else begin
            bootMeta_reg <= bootModePin;
            bootSync_reg <= bootMeta_reg;
            runReq_reg   <= 1'b0;
            if (push)
                sendPend_reg <= 1'b0;
            if (!busy) begin
                case (state_reg)
                    S_IDLE: begin
                        if (bootSync_reg)
                            state_reg <= S_BAUD;
                    end
                    S_BAUD: begin
                        if (take) begin
                            if (rxData == `SBCH_BAUD_CODE && baudOk && !rxError) begin
                                sendPend_reg <= 1'b1;
                                sendByte_reg <= `SBCH_BAUD_CODE;
                                state_reg    <= S_CMD;
                            end else begin
                                state_reg <= S_DEAD;
                            end
                        end
                    end
                    S_CMD: begin
                        if (take) begin
                            sendPend_reg <= 1'b1;
                            sendByte_reg <= rxData;
                            cmd_reg      <= rxData;
                            lastHi_reg   <= rxData[7:4];
                            cnt_reg      <= 19'h00000;
                            sum_reg      <= 16'h0000;
                            rxErr_reg    <= 1'b0;
                            pwBad_reg    <= 1'b0;
                            if (rxError) begin
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_RX);
                                lastHi_reg   <= lastHi_reg;
                            end else begin
                                case (rxData)
                                    `SBCH_CMD_RAM: begin
                                        if (protActive)
                                            sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_PROT);
                                        else
                                            state_reg <= S_PW;
                                    end
                                    `SBCH_CMD_PROT: state_reg <= S_PW;
                                    `SBCH_CMD_PROG: begin
                                        if (!erased_reg)
                                            sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_NOERASE);
                                        else if (protActive)
                                            sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_PROT);
                                        else
                                            state_reg <= S_HDR;
                                    end
                                    `SBCH_CMD_ERASE: begin
                                        // No password stage, so a lost password can be recovered
                                        eraseReq_reg <= 1'b1;
                                        state_reg    <= S_ERASE;
                                    end
                                    `SBCH_CMD_SUM:  state_reg <= S_SUM;
                                    `SBCH_CMD_INFO: state_reg <= S_INFO;
                                    default: begin
                                        sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_CMD);
                                        lastHi_reg   <= lastHi_reg;
                                    end
                                endcase
                            end
                        end
                    end
                    S_PW: begin
                        if (take) begin
                            sum_reg[7:0]    <= ckSum;
                            rxErr_reg       <= ckErr;
                            byte_reg        <= rxData;
                            flashRdAddr_reg <= `SBCH_PW_BASE + {5'h00, cnt_reg};
                            flashRdReq_reg  <= 1'b1;
                            state_reg       <= S_PWRD;
                        end
                    end
                    S_PWRD: begin
                        if (flashRdAck) begin
                            flashRdReq_reg <= 1'b0;
                            if (flashRdData != byte_reg)
                                pwBad_reg <= 1'b1;
                            cnt_reg   <= cnt_reg + 19'h00001;
                            state_reg <= (cnt_reg[4:0] == `SBCH_PW_LAST) ? S_PWCK : S_PW;
                        end
                    end
                    S_PWCK: begin
                        if (take) begin
                            sendPend_reg <= 1'b1;
                            state_reg    <= S_CMD;
                            cnt_reg      <= 19'h00000;
                            sum_reg      <= 16'h0000;
                            if (ckErr)
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_RX);
                            else if (ckSum != 8'h00 || pwBad_reg)
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_CMD);
                            else begin
                                sendByte_reg <= cmd_reg;
                                if (cmd_reg == `SBCH_CMD_PROT) begin
                                    protReq_reg <= 1'b1;
                                    state_reg   <= S_PROT;
                                end else
                                    state_reg <= S_HDR;
                            end
                        end
                    end
                    S_HDR: begin
                        if (take) begin
                            sum_reg[7:0] <= ckSum;
                            rxErr_reg    <= ckErr;
                            cnt_reg      <= cnt_reg + 19'h00001;
                            if (cnt_reg[4:0] < 5'h04)
                                addr_reg <= {addr_reg[23:0], rxData};
                            else
                                len_reg <= {len_reg[7:0], rxData};
                            if (cnt_reg[4:0] == `SBCH_HDR_LAST)
                                state_reg <= S_HDRCK;
                        end
                    end
                    S_HDRCK: begin
                        if (take) begin
                            sendPend_reg  <= 1'b1;
                            state_reg     <= S_CMD;
                            sum_reg       <= 16'h0000;
                            runAddr_reg   <= addr_reg;
                            wrAddr_reg    <= addr_reg;
                            wrToFlash_reg <= (cmd_reg == `SBCH_CMD_PROG);
                            if (ckErr)
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_RX);
                            else if (ckSum != 8'h00 ||
                                     (cmd_reg == `SBCH_CMD_RAM && !ramFits))
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_CMD);
                            else begin
                                // Range and evenness of a program image are the controller's duty
                                sendByte_reg <= cmd_reg;
                                state_reg    <= (len_reg == 16'h0000) ? S_DCK : S_DATA;
                            end
                        end
                    end
                    S_DATA: begin
                        if (take) begin
                            sum_reg[7:0] <= ckSum;
                            rxErr_reg    <= ckErr;
                            wrData_reg   <= rxData;
                            wrReq_reg    <= 1'b1;
                            state_reg    <= S_WR;
                        end
                    end
                    S_WR: begin
                        if (wrDone) begin
                            // Written once per erase; rewrites rely on a prior chip erase
                            wrReq_reg  <= 1'b0;
                            wrAddr_reg <= wrAddr_reg + 32'h00000001;
                            len_reg    <= len_reg - 16'h0001;
                            state_reg  <= (len_reg == 16'h0001) ? S_DCK : S_DATA;
                        end
                    end
                    S_DCK: begin
                        if (take) begin
                            sendPend_reg <= 1'b1;
                            state_reg    <= S_CMD;
                            if (ckErr)
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_RX);
                            else if (ckSum != 8'h00)
                                sendByte_reg <= errAck(lastHi_reg, `SBCH_ERR_CMD);
                            else begin
                                sendByte_reg <= cmd_reg;
                                if (cmd_reg == `SBCH_CMD_RAM)
                                    state_reg <= S_RUN;
                            end
                        end
                    end
                    S_RUN: begin
                        // Last ack is already buffered; the loaded program owns the chip now
                        runReq_reg <= 1'b1;
                        state_reg  <= S_DEAD;
                    end
                    S_ERASE: begin
                        if (eraseDone) begin
                            // Flash side drops protection along with the data
                            eraseReq_reg <= 1'b0;
                            erased_reg   <= erased_reg | eraseOk;
                            sendPend_reg <= 1'b1;
                            sendByte_reg <= eraseOk ? `SBCH_ERASE_OK : `SBCH_ERASE_FAIL;
                            state_reg    <= S_CMD;
                        end
                    end
                    S_PROT: begin
                        if (protDone) begin
                            protReq_reg  <= 1'b0;
                            sendPend_reg <= 1'b1;
                            sendByte_reg <= protOk ? `SBCH_PROT_OK : `SBCH_PROT_FAIL;
                            byte_reg     <= protOk ? `SBCH_PROT_FIN_OK : `SBCH_PROT_FIN_FAIL;
                            state_reg    <= S_TAIL;
                        end
                    end
                    S_TAIL: begin
                        sendPend_reg <= 1'b1;
                        sendByte_reg <= byte_reg;
                        state_reg    <= S_CMD;
                    end
                    S_SUM: begin
                        if (!flashRdReq_reg) begin
                            flashRdAddr_reg <= `SBCH_FLASH_BASE + {5'h00, cnt_reg};
                            flashRdReq_reg  <= 1'b1;
                        end else if (flashRdAck) begin
                            flashRdReq_reg <= 1'b0;
                            sum_reg        <= sum_reg + {8'h00, flashRdData};
                            cnt_reg        <= cnt_reg + 19'h00001;
                            if (cnt_reg == SUM_LAST) begin
                                // High byte first, then low byte
                                sendPend_reg <= 1'b1;
                                sendByte_reg <= sum_reg[15:8] + {7'h00, ({1'b0, sum_reg[7:0]} +
                                                {1'b0, flashRdData}) > 9'h0ff};
                                byte_reg     <= sum_reg[7:0] + flashRdData;
                                state_reg    <= S_TAIL;
                            end
                        end
                    end
                    S_INFO: begin
                        if (!flashRdReq_reg) begin
                            flashRdAddr_reg <= `SBCH_INFO_BASE + {5'h00, cnt_reg};
                            flashRdReq_reg  <= 1'b1;
                        end else if (flashRdAck) begin
                            flashRdReq_reg <= 1'b0;
                            sendPend_reg   <= 1'b1;
                            sendByte_reg   <= flashRdData;
                            cnt_reg        <= cnt_reg + 19'h00001;
                            if (cnt_reg[4:0] == `SBCH_INFO_LAST)
                                state_reg <= S_CMD;
                        end
                    end
                    S_DEAD: state_reg <= S_DEAD;
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: sbch_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sbch_checker (
    // Clock, reset, characters
    input wire logic        core_clk, rst_n, rxReady, txValid, txReady,
    input wire logic [7:0]  txData,
    // Flash side and run hand-off
    input wire logic        flashRdReq_reg, flashRdAck, wrReq_reg, wrDone, eraseReq_reg,
    input wire logic        eraseDone, protReq_reg, protDone, runReq_reg,
    input wire logic [23:0] flashRdAddr_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_reset_idle: assert property ($rose(rst_n) |-> !txValid && !rxReady)
        else $error("busy after reset");
    chk_tx_holds: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("tx byte lost");
    chk_rd_holds: assert property (flashRdReq_reg && !flashRdAck |=>
        flashRdReq_reg && $stable(flashRdAddr_reg)) else $error("read dropped");
    chk_rd_drops: assert property (flashRdAck |=> !flashRdReq_reg)
        else $error("read held");
    chk_wr_holds: assert property (wrReq_reg && !wrDone |=> wrReq_reg)
        else $error("write dropped");
    chk_erase_holds: assert property (eraseReq_reg && !eraseDone |=> eraseReq_reg)
        else $error("erase dropped");
    chk_prot_holds: assert property (protReq_reg && !protDone |=> protReq_reg)
        else $error("protect dropped");
    chk_run_pulse: assert property (runReq_reg |=> !runReq_reg [*8])
        else $error("run repeated");
    chk_busy_stall: assert property (eraseReq_reg || flashRdReq_reg |-> !rxReady)
        else $error("rx while busy");
endmodule
bind sbch_boot_handler sbch_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .rxReady(rxReady), .txValid(txValid), .txReady(txReady), .txData(txData),
    .flashRdReq_reg(flashRdReq_reg), .flashRdAck(flashRdAck), .wrReq_reg(wrReq_reg),
    .wrDone(wrDone), .eraseReq_reg(eraseReq_reg), .eraseDone(eraseDone),
    .protReq_reg(protReq_reg), .protDone(protDone), .runReq_reg(runReq_reg),
    .flashRdAddr_reg(flashRdAddr_reg));
`default_nettype wire

// File: sbch_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbch_flash_model (
    input wire logic        core_clk, rst_n, rdReq, wrReq, erReq, prReq,
    input wire logic [23:0] rdAddr,
    output logic            rdAck, wrDone, erDone, prDone, prot,
    output logic [7:0]      rdData
);
    logic [1:0] cnt;
    // Answer only on counter wrap, so latency swings between 1 and 4 cycles
    always @(posedge core_clk) begin
        cnt <= rst_n ? cnt + 2'd1 : 2'd0;
        rdAck <= rst_n && rdReq && !rdAck && cnt == 2'd3;
        rdData <= !rst_n ? 8'h00 : (rdReq && cnt == 2'd3) ? rdAddr[7:0] ^ 8'h5a : ~rdData;
        wrDone <= rst_n && wrReq && !wrDone && cnt == 2'd3;
        erDone <= rst_n && erReq && !erDone && cnt == 2'd3;
        prDone <= rst_n && prReq && !prDone && cnt == 2'd3;
        if (!rst_n || (erReq && erDone)) prot <= 1'b0;
        else if (prReq && prDone) prot <= 1'b1;
    end
endmodule
`default_nettype wire

// File: sbch_boot_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin nChecks++; if ((a) !== (e)) begin nMismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module sbch_boot_handler_test;
    logic       core_clk = 0, rst_n = 0, rxValid = 0, rxError = 0, txReady = 0;
    logic [7:0] rxData = 8'h00, rdData, txData;
    logic       rxReady, txValid, rdReq, rdAck, wrReq, wrDone, erReq, erDone, prReq, prDone;
    logic       prot, runReq, wrFlash, baudOk = 1'b1, runSeen = 1'b0;
    logic [7:0]  wrData;
    logic [31:0] wrAddr;
    logic [40:0] wrSeen = '0;
    logic [23:0] rdAddr;
    logic [31:0] runAddr;
    int nMismatch = 0, nChecks = 0;
    always #25 core_clk = ~core_clk;
    sbch_boot_handler #(.FLASH_BYTES(16)) u_sbch_boot_handler (.core_clk(core_clk),
        .rst_n(rst_n), .bootModePin(1'b1), .baudOk(baudOk), .rxValid(rxValid), .rxData(rxData),
        .rxError(rxError), .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txReady(txReady), .flashRdReq_reg(rdReq), .flashRdAddr_reg(rdAddr),
        .flashRdAck(rdAck), .flashRdData(rdData), .wrReq_reg(wrReq), .wrToFlash_reg(wrFlash),
        .wrAddr_reg(wrAddr), .wrData_reg(wrData), .wrDone(wrDone), .protActive(prot),
        .eraseReq_reg(erReq), .eraseDone(erDone), .eraseOk(1'b1), .protReq_reg(prReq),
        .protDone(prDone), .protOk(1'b1), .runReq_reg(runReq), .runAddr_reg(runAddr));
    sbch_flash_model u_sbch_flash_model (.core_clk(core_clk), .rst_n(rst_n), .rdReq(rdReq),
        .wrReq(wrReq), .erReq(erReq), .prReq(prReq), .rdAddr(rdAddr), .rdAck(rdAck),
        .wrDone(wrDone), .erDone(erDone), .prDone(prDone), .prot(prot), .rdData(rdData));
    // Run pulse lasts one cycle, so it is caught here rather than polled
    always @(posedge core_clk) begin
        if (runReq) runSeen <= 1'b1;
        if (wrReq && wrDone) wrSeen <= {wrFlash, wrAddr, wrData};
    end
    task automatic results;
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tmo(input int i);
        if (i >= 400) begin nMismatch++; results(); end
    endtask
    task automatic send(input logic [7:0] b, input logic e = 1'b0);
        int i;
        @(posedge core_clk); rxData <= b; rxError <= e; rxValid <= 1'b1;
        i = 0;
        do @(negedge core_clk); while (rxReady !== 1'b1 && ++i < 400);
        tmo(i);
        @(posedge core_clk); rxValid <= 1'b0;
    endtask
    // Drain pops each byte two cycles after it lands, keeping pace with two-byte answers, so the buffer never holds more than one byte
    task automatic expb(input logic [7:0] m, input logic [7:0] e);
        int i;
        i = 0;
        do @(negedge core_clk); while (txValid !== 1'b1 && ++i < 400);
        tmo(i);
        `CHK("answer", e & m, txData & m)
        @(posedge core_clk); txReady <= 1'b1;
        @(posedge core_clk); txReady <= 1'b0;
    endtask
    task automatic pw(input logic [7:0] bad);
        logic [7:0] s;
        s = 8'h00;
        for (int a = 8'hf4; a <= 8'hff; a++) begin send(a[7:0] ^ 8'h5a); s += a[7:0] ^ 8'h5a; end
        send(-s ^ bad);
    endtask
    task automatic hdr(input logic [31:0] a, input logic [15:0] n);
        logic [7:0] s;
        s = a[31:24] + a[23:16] + a[15:8] + a[7:0] + n[15:8] + n[7:0];
        send(a[31:24]); send(a[23:16]); send(a[15:8]); send(a[7:0]);
        send(n[15:8]); send(n[7:0]); send(-s);
    endtask
    task automatic t_errors;
        send(8'h86); expb(8'hff, 8'h86);
        send(8'h50); expb(8'h0f, 8'h04);
        send(8'h77); expb(8'h0f, 8'h01);
        send(8'h40, 1'b1); expb(8'h0f, 8'h08);
    endtask
    task automatic t_reads;
        logic [15:0] s;
        send(8'h40); expb(8'hff, 8'h40); expb(8'hff, 8'h4f);
        send(8'h30); expb(8'hff, 8'h30);
        for (int k = 0; k < 4; k++) expb(8'hff, (8'hf0 + k[7:0]) ^ 8'h5a);
        s = 16'h0000;
        for (int k = 0; k < 16; k++) s += {8'h00, k[7:0] ^ 8'h5a};
        send(8'h20); expb(8'hff, 8'h20); expb(8'hff, s[15:8]); expb(8'hff, s[7:0]);
    endtask
    task automatic t_protect;
        send(8'h60); expb(8'hff, 8'h60); pw(8'h01); expb(8'hff, 8'h61);
        send(8'h60); expb(8'hff, 8'h60); pw(8'h00); expb(8'hff, 8'h60);
        expb(8'hff, 8'h6f); expb(8'hff, 8'h31);
        send(8'h50); expb(8'h0f, 8'h06);
        send(8'h40); expb(8'hff, 8'h40); expb(8'hff, 8'h4f);
        send(8'h50); expb(8'hff, 8'h50);
        hdr(32'h00010000, 16'h0001); expb(8'hff, 8'h50);
        send(8'h3c); send(8'hc4); expb(8'hff, 8'h50);
        `CHK("flash write", {1'b1, 32'h00010000, 8'h3c}, wrSeen)
    endtask
    task automatic t_ram;
        int i;
        send(8'h10); expb(8'hff, 8'h10); pw(8'h00); expb(8'hff, 8'h10);
        hdr(32'h00001000, 16'h0001); expb(8'hff, 8'h10);
        send(8'ha5); send(8'h5b); expb(8'hff, 8'h10);
        `CHK("ram write", {1'b0, 32'h00001000, 8'ha5}, wrSeen)
        i = 0;
        do @(negedge core_clk); while (runSeen !== 1'b1 && ++i < 400);
        tmo(i);
        `CHK("run address", 32'h00001000, runAddr)
    endtask
    // Unreachable rate must leave the link silent until the next reset
    task automatic t_nobaud;
        @(posedge core_clk); rst_n <= 1'b0; baudOk <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        send(8'h86); repeat (20) @(negedge core_clk);
        `CHK("silent stop", 2'b00, {txValid, rxReady})
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        t_errors(); t_reads(); t_protect(); t_ram(); t_nobaud();
        results();
    end
endmodule
`default_nettype wire
